// >>> rtl/fpir_pkg.sv
// flow pulse integrity and rate core: shared constants and types
// assumes one 20 MHz clock; configuration ports are static on that clock
package fpir_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned GATE_TIME_MS = 1000;
    localparam int unsigned GATE_CYCLES  = GATE_TIME_MS * (CLK_HZ / 1000);
    // ==========================================================
    // arithmetic
    localparam int          DIV_W     = 40;
    localparam logic [5:0]  DIV_STEPS = 6'h28;
    localparam logic [11:0] TB_MIN    = 12'h03c;
    localparam logic [11:0] TB_HOUR   = 12'he10;
    localparam logic [9:0]  ACC_DIV   = 10'h3e8;   // accuracy in tenths, /100 percent
    localparam logic [1:0]  EMIN_MUL  = 2'h2;
    localparam logic [3:0]  TBL_N     = 4'ha;
    localparam logic [3:0]  TBL_LAST  = 4'h9;
    localparam logic [4:0]  ERR_MISSING = 5'h0d;
    localparam logic [4:0]  ERR_SIMUL   = 5'h12;
    localparam logic [20:0] ROLL_D0 = 21'hf4240;
    localparam logic [20:0] ROLL_D1 = 21'h186a0;
    localparam logic [20:0] ROLL_D2 = 21'h02710;
    localparam logic [20:0] ROLL_D3 = 21'h003e8;
    // ==========================================================
    // types
    typedef enum logic [1:0] {FT_SINGLE, FT_QUAD, FT_ANALOG} fpir_ftype_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_DIV} fpir_state_t;
    typedef enum logic [1:0] {PH_INTERP, PH_RATE, PH_FILT} fpir_phase_t;
    typedef struct packed {
        fpir_ftype_t flow_input_type;
        logic        pulse_check_enable;
        logic        nl_enable;
        logic        rate_per_hour;
        logic [15:0] vmin;                  // litres
        logic [7:0]  acc_tenths;            // accuracy class x10
        logic [15:0] scale;                 // pulses per litre, 8.8
        logic [1:0]  total_decimal_setting; // decimals of a 6 digit total
        logic [6:0]  filt_a;
    } fpir_cfg_t;
    typedef struct packed {
        logic        wr;
        logic [3:0]  idx;
        logic [15:0] freq;                  // Hz, descending, 0 ends
        logic [15:0] factor;                // 8.8
    } fpir_tbl_wr_t;
    typedef struct packed {
        logic        alarm_n;
        logic        relay_en;
        logic        stop_led;
        logic        flow_err;
        logic        phase_err;
        logic [4:0]  err_code;
    } fpir_alarm_t;
    typedef struct packed {
        logic        deviation_limit_prompt;
        logic [15:0] dev_value;             // Emin litres, 8.8
        logic        quantity_limit_prompt;
        logic [15:0] qty_value;
    } fpir_prompt_t;
    typedef struct packed {
        logic [2:0]  sa, sb, ss;
        logic        la, lb, ls;
        logic [31:0] gate;
        logic [15:0] fcnt, freq;
        logic [31:0] cnt_a, cnt_b, cnt_both;
        fpir_alarm_t alm;
        fpir_prompt_t prm;
        logic [9:0][15:0] tf, ts;
        fpir_state_t st;
        fpir_phase_t ph;
        logic [3:0]  idx;
        logic        neg;
        logic [15:0] s_eff;
        logic [DIV_W-1:0] num, den, rem;
        logic [5:0]  dcnt;
        logic [31:0] rate, rate_filt;
    } fpir_state_s_t;
endpackage : fpir_pkg

// >>> rtl/fpir_core.sv
// flow pulse integrity checking, rate with non-linearity table and filter
// assumes pulse and stop pins are asynchronous; configuration is on core_clk
`timescale 1ns/1ns
// Operation
// - Emin is two Vmin times accuracy over hundred
// - channel volume difference over limit flags flow
// - simultaneous pulse volume over limit flags phase
// - check runs span twice Vmin, twice Emin
// - run complete clears accumulators, next run starts
// - scale below 1/Emin shows deviation prompt
// - rollover not above twice Vmin shows prompt
// - rate is frequency times timebase over scale
// - ten point frequency and factor table
// - no table correction with analog input
// - linear interpolation, first factor held above
// - zero frequency ends table; tenth forced zero
// - programmable filter smooths displayed rate
// - filter constant one passes rate unchanged
// - checking only for quadrature with check enabled
// - alarm drives output low, relays off, stop lit
module fpir_core import fpir_pkg::*; #(
    parameter int unsigned GATE_CYC = GATE_CYCLES
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          clk_en,
    // flowmeter pins and stop key
    input  wire logic          pulse_a,
    input  wire logic          pulse_b,
    input  wire logic          stop_key,
    // configuration
    input  wire fpir_cfg_t     cfg,
    input  wire fpir_tbl_wr_t  tbl_wr,
    // results
    output fpir_alarm_t        alarm,
    output fpir_prompt_t       prompt,
    output logic [31:0]        rate_out,
    output logic [15:0]        freq_out
);
    fpir_state_s_t r_reg, r_next;

    assign alarm    = r_reg.alm;
    assign prompt   = r_reg.prm;
    assign rate_out = r_reg.rate_filt;
    assign freq_out = r_reg.freq;

    // ==========================================================
    // derived check limits
    logic        quad_act;
    logic [39:0] emin_q8, emin_p, run_len;
    logic [20:0] roll;
    always_comb begin
        quad_act = (cfg.flow_input_type == FT_QUAD) && cfg.pulse_check_enable;
        emin_q8  = (40'(cfg.vmin) * 40'(cfg.acc_tenths) * 40'(EMIN_MUL) << 8)
                   / 40'(ACC_DIV);
        // counts stand in for volume: one pulse is 1/scale litres
        emin_p   = (emin_q8 * 40'(cfg.scale)) >> 16;
        run_len  = (40'(cfg.vmin) * 40'(EMIN_MUL) * 40'(cfg.scale)) >> 8;
        case (cfg.total_decimal_setting)
            2'h0:    roll = ROLL_D0;
            2'h1:    roll = ROLL_D1;
            2'h2:    roll = ROLL_D2;
            default: roll = ROLL_D3;
        endcase
    end

    // ==========================================================
    // next state
    logic        ea, eb, estop, set_f, set_p, nl_act;
    logic [31:0] na, nb, nboth, dab;
    logic [DIV_W-1:0] rem2;
    logic [15:0] s_lo, s_hi;
    always_comb begin
        r_next = r_reg;
        ea = 1'b0;
        eb = 1'b0;
        estop = 1'b0;
        set_f = 1'b0;
        set_p = 1'b0;
        na = r_reg.cnt_a;
        nb = r_reg.cnt_b;
        nboth = r_reg.cnt_both;
        dab = 32'h0;
        rem2 = '0;
        s_lo = r_reg.ts[r_reg.idx];
        s_hi = r_reg.ts[r_reg.idx - 4'h1];
        nl_act = cfg.nl_enable && (cfg.flow_input_type != FT_ANALOG);
        // pins: a level counts once the second and third stages agree
        r_next.sa = {r_reg.sa[1:0], pulse_a};
        r_next.sb = {r_reg.sb[1:0], pulse_b};
        r_next.ss = {r_reg.ss[1:0], stop_key};
        if (r_reg.sa[1] == r_reg.sa[2]) begin
            r_next.la = r_reg.sa[2];
            ea = r_reg.sa[2] && !r_reg.la;
        end
        if (r_reg.sb[1] == r_reg.sb[2]) begin
            r_next.lb = r_reg.sb[2];
            eb = r_reg.sb[2] && !r_reg.lb;
        end
        if (r_reg.ss[1] == r_reg.ss[2]) begin
            r_next.ls = r_reg.ss[2];
            estop = r_reg.ss[2] && !r_reg.ls;
        end
        // integrity check, evaluated at every pulse
        if (quad_act && (ea || eb)) begin
            na = r_reg.cnt_a + 32'(ea);
            nb = r_reg.cnt_b + 32'(eb);
            nboth = r_reg.cnt_both + 32'(ea && eb);
            dab = (na > nb) ? na - nb : nb - na;
            set_f = 40'(dab) > (emin_p << 1);
            set_p = 40'(nboth) > (emin_p << 1);
            if (40'(na) >= run_len) begin
                na = 32'h0;
                nb = 32'h0;
                nboth = 32'h0;
            end
            r_next.cnt_a = na;
            r_next.cnt_b = nb;
            r_next.cnt_both = nboth;
        end else if (!quad_act) begin
            r_next.cnt_a = 32'h0;
            r_next.cnt_b = 32'h0;
            r_next.cnt_both = 32'h0;
        end
        // stop clears, a new error in the same cycle still lands
        r_next.alm.flow_err  = set_f || (r_reg.alm.flow_err && !estop);
        r_next.alm.phase_err = set_p || (r_reg.alm.phase_err && !estop);
        r_next.alm.alarm_n   = !(r_next.alm.flow_err || r_next.alm.phase_err);
        r_next.alm.relay_en  = r_next.alm.alarm_n;
        r_next.alm.stop_led  = !r_next.alm.alarm_n;
        r_next.alm.err_code  = r_next.alm.flow_err ? ERR_MISSING :
                               r_next.alm.phase_err ? ERR_SIMUL : 5'h00;
        // configuration prompts
        r_next.prm.deviation_limit_prompt = quad_act && (emin_p == 40'h0);
        r_next.prm.dev_value = emin_q8[15:0];
        r_next.prm.quantity_limit_prompt =
            quad_act && (22'(roll) <= (22'(cfg.vmin) << 1));
        r_next.prm.qty_value = cfg.vmin;
        // correction table, tenth frequency always ends it
        if (tbl_wr.wr && (tbl_wr.idx < TBL_N)) begin
            r_next.tf[tbl_wr.idx] = tbl_wr.freq;
            r_next.ts[tbl_wr.idx] = tbl_wr.factor;
        end
        r_next.tf[TBL_LAST] = 16'h0000;
        // frequency gate
        r_next.fcnt = r_reg.fcnt + 16'(ea && r_reg.fcnt != 16'hffff);
        r_next.gate = r_reg.gate + 32'h1;
        // rate pipeline; a gate that ends while busy stays open and closes on the first idle cycle
        case (r_reg.st)
            ST_IDLE: begin
                if (r_reg.gate >= 32'(GATE_CYC - 1)) begin
                    r_next.gate = 32'h0;
                    r_next.fcnt = 16'(ea); // an edge on the closing cycle opens the next gate
                    r_next.freq = r_reg.fcnt;
                    r_next.idx  = 4'h1;
                    r_next.s_eff = cfg.scale;
                    r_next.st = nl_act ? ST_SEARCH : ST_DIV;
                    r_next.ph = PH_RATE;
                    r_next.num = DIV_W'({r_reg.fcnt, 8'h00})
                                 * DIV_W'(cfg.rate_per_hour ? TB_HOUR : TB_MIN);
                    r_next.den = DIV_W'(cfg.scale);
                    r_next.rem = '0;
                    r_next.dcnt = 6'h0;
                end
            end
            ST_SEARCH: begin
                // first point governs everything above it
                if (r_reg.freq >= r_reg.tf[0] || r_reg.tf[0] == 16'h0) begin
                    r_next.s_eff = r_reg.ts[0];
                    r_next.num = DIV_W'({r_reg.freq, 8'h00})
                                 * DIV_W'(cfg.rate_per_hour ? TB_HOUR : TB_MIN);
                    r_next.den = DIV_W'(r_reg.ts[0]);
                    r_next.st = ST_DIV;
                end else if (r_reg.freq >= r_reg.tf[r_reg.idx]) begin
                    // zero point keeps its own written factor; the span slopes to it at 0 Hz
                    r_next.neg = s_hi < s_lo;
                    r_next.num = DIV_W'(s_hi < s_lo ? s_lo - s_hi : s_hi - s_lo)
                                 * DIV_W'(r_reg.freq - r_reg.tf[r_reg.idx]);
                    r_next.den = DIV_W'(r_reg.tf[r_reg.idx - 4'h1] - r_reg.tf[r_reg.idx]);
                    r_next.ph = PH_INTERP;
                    r_next.st = ST_DIV;
                end else begin
                    r_next.idx = r_reg.idx + 4'h1;
                end
                r_next.rem = '0;
                r_next.dcnt = 6'h0;
            end
            ST_DIV: begin
                // restoring divide, quotient shifts into num
                rem2 = {r_reg.rem[DIV_W-2:0], r_reg.num[DIV_W-1]};
                r_next.num = {r_reg.num[DIV_W-2:0], rem2 >= r_reg.den};
                r_next.rem = (rem2 >= r_reg.den) ? rem2 - r_reg.den : rem2;
                r_next.dcnt = r_reg.dcnt + 6'h1;
                if (r_reg.dcnt == DIV_STEPS - 6'h1) begin
                    r_next.rem = '0;
                    r_next.dcnt = 6'h0;
                    case (r_reg.ph)
                        PH_INTERP: begin
                            r_next.s_eff = r_reg.neg ? s_lo - r_next.num[15:0]
                                                     : s_lo + r_next.num[15:0];
                            r_next.num = DIV_W'({r_reg.freq, 8'h00})
                                * DIV_W'(cfg.rate_per_hour ? TB_HOUR : TB_MIN);
                            r_next.den = DIV_W'(r_next.s_eff);
                            r_next.ph = PH_RATE;
                        end
                        PH_RATE: begin
                            r_next.rate = (r_reg.den == '0) ? 32'h0 : r_next.num[31:0];
                            if (cfg.filt_a <= 7'h01) begin
                                r_next.rate_filt = r_next.rate;
                                r_next.st = ST_IDLE;
                            end else begin
                                r_next.neg = r_next.rate < r_reg.rate_filt;
                                r_next.num = DIV_W'(r_next.neg
                                    ? r_reg.rate_filt - r_next.rate
                                    : r_next.rate - r_reg.rate_filt);
                                r_next.den = DIV_W'(cfg.filt_a);
                                r_next.ph = PH_FILT;
                            end
                        end
                        default: begin
                            r_next.rate_filt = r_reg.neg
                                ? r_reg.rate_filt - r_next.num[31:0]
                                : r_reg.rate_filt + r_next.num[31:0];
                            r_next.st = ST_IDLE;
                        end
                    endcase
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.alm.alarm_n <= 1'b1;
            r_reg.alm.relay_en <= 1'b1;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_flow_set;
        clk_en && set_f |=> alarm.flow_err && !alarm.alarm_n;
    endproperty
    a_flow_set: assert property (p_flow_set) else $error("flow error not flagged");
    property p_phase_set;
        clk_en && set_p |=> alarm.phase_err && alarm.stop_led;
    endproperty
    a_phase_set: assert property (p_phase_set) else $error("phase error not flagged");
    property p_run_clear;
        clk_en && quad_act && (ea || eb) && 40'(na) == 40'h0 && r_reg.cnt_a != 32'h0
            |=> r_reg.cnt_both == 32'h0 && r_reg.cnt_b == 32'h0;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("run not restarted");
    property p_dev_prompt;
        clk_en && quad_act && emin_p == 40'h0 |=> prompt.deviation_limit_prompt;
    endproperty
    a_dev_prompt: assert property (p_dev_prompt) else $error("deviation prompt missing");
    property p_qty_prompt;
        clk_en && !quad_act |=> !prompt.quantity_limit_prompt;
    endproperty
    a_qty_prompt: assert property (p_qty_prompt) else $error("quantity prompt stray");
    property p_inactive;
        !quad_act && !alarm.flow_err && !alarm.phase_err |=> !alarm.flow_err;
    endproperty
    a_inactive: assert property (p_inactive) else $error("check ran while off");
    sequence s_alarm_on;
        alarm.flow_err || alarm.phase_err;
    endsequence
    sequence s_alarm_outs;
        !alarm.alarm_n && !alarm.relay_en && alarm.stop_led;
    endsequence
    property p_alarm_outs;
        s_alarm_on |-> s_alarm_outs;
    endproperty
    a_alarm_outs: assert property (p_alarm_outs) else $error("alarm outputs wrong");
    property p_alarm_hold;
        (alarm.flow_err && !estop |=> alarm.flow_err)
            and (alarm.phase_err && !estop |=> alarm.phase_err);
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");
    property p_tbl_end;
        r_reg.tf[TBL_LAST] == 16'h0000;
    endproperty
    a_tbl_end: assert property (p_tbl_end) else $error("tenth point not zero");
    property p_pass;
        clk_en && r_reg.st == ST_DIV && r_reg.ph == PH_RATE && cfg.filt_a == 7'h01
            && r_reg.dcnt == DIV_STEPS - 6'h1 |=> rate_out == r_reg.rate;
    endproperty
    a_pass: assert property (p_pass) else $error("unfiltered rate differs");
endmodule : fpir_core

// >>> dv/fpir_flowmeter_model.sv
// flowmeter sensor model: two push-pull pulse outputs, single pulses or a steady train
// assumes core_clk is the bench clock; outputs change just after its rising edge
`timescale 1ns/1ns
module fpir_flowmeter_model (
    // clock
    input  wire logic core_clk,
    // sensor outputs, actively driven so no released level exists
    output logic      pulse_a,
    output logic      pulse_b
);
    initial begin
        pulse_a = 1'b0;
        pulse_b = 1'b0;
    end

    // ==========================================================
    // single pulses, four cycles high and low to clear the pin synchroniser
    // lag puts the b edge after the a edge, as a healthy quadrature pair does
    task automatic pulse(input logic en_a, input logic en_b, input logic lag);
        @(posedge core_clk);
        pulse_a <= en_a;
        pulse_b <= en_b & ~lag;
        repeat (4) @(posedge core_clk);
        pulse_a <= 1'b0;
        pulse_b <= en_b & lag;
        repeat (4) @(posedge core_clk);
        pulse_b <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pulse

    // ==========================================================
    // steady train on channel a, period ten cycles
    task automatic train(input int periods);
        repeat (periods) begin
            @(posedge core_clk);
            pulse_a <= 1'b1;
            repeat (4) @(posedge core_clk);
            pulse_a <= 1'b0;
            repeat (5) @(posedge core_clk);
        end
    endtask : train
endmodule : fpir_flowmeter_model

// >>> dv/tb_flow_pulse_integrity_rate.sv
// self-checking bench for the flow pulse integrity and rate core
// assumes fpir_pkg, fpir_core and the flowmeter model are compiled first
`timescale 1ns/1ns
module tb_flow_pulse_integrity_rate import fpir_pkg::*;;
    localparam int GATE  = 200;
    localparam int LIMIT = 20000;
    logic         core_clk = 1'b0;
    logic         nrst     = 1'b0;
    logic         clk_en   = 1'b1;
    logic         stop_key = 1'b0;
    logic         pulse_a;
    logic         pulse_b;
    fpir_cfg_t    cfg      = '0;
    fpir_tbl_wr_t tbl_wr   = '0;
    fpir_alarm_t  alarm;
    fpir_prompt_t prompt;
    logic [31:0]  rate_out;
    logic [15:0]  freq_out;
    int           error_cnt  = 0;
    int           n_compared = 0;
    int           cyc        = 0;

    always #25 core_clk = ~core_clk;

    fpir_core #(.GATE_CYC(GATE)) fpir_core_i (
        .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
        .pulse_a(pulse_a), .pulse_b(pulse_b), .stop_key(stop_key),
        .cfg(cfg), .tbl_wr(tbl_wr), .alarm(alarm), .prompt(prompt),
        .rate_out(rate_out), .freq_out(freq_out));
    fpir_flowmeter_model fpir_flowmeter_model_i (
        .core_clk(core_clk), .pulse_a(pulse_a), .pulse_b(pulse_b));

    // ==========================================================
    // verdict and hang guard
    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    // ==========================================================
    // compares
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk_alarm(input fpir_alarm_t got, input fpir_alarm_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_alarm

    task automatic chk_prompt(input fpir_prompt_t got, input fpir_prompt_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_prompt

    function automatic fpir_alarm_t alm(input logic fe, input logic pe, input logic [4:0] code);
        alm = '{alarm_n: ~(fe | pe), relay_en: ~(fe | pe), stop_led: fe | pe,
                flow_err: fe, phase_err: pe, err_code: code};
    endfunction : alm

    // ==========================================================
    // helpers; vmin and scale below give a limit of four pulses per run
    task automatic do_reset();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    task automatic set_cfg(input fpir_ftype_t ft, input logic chk, input logic [15:0] vmin,
                           input logic [15:0] scale);
        cfg <= '{flow_input_type: ft, pulse_check_enable: chk, nl_enable: 1'b0,
                 rate_per_hour: 1'b0, vmin: vmin, acc_tenths: 8'h0a, scale: scale,
                 total_decimal_setting: 2'h0, filt_a: 7'h01};
        do_reset();
    endtask : set_cfg

    task automatic press_stop();
        stop_key <= 1'b1;
        repeat (4) @(posedge core_clk);
        stop_key <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : press_stop

    task automatic tbl_put(input logic [3:0] i, input logic [15:0] f, input logic [15:0] k);
        tbl_wr <= '{wr: 1'b1, idx: i, freq: f, factor: k};
        @(posedge core_clk);
        tbl_wr.wr <= 1'b0;
        @(posedge core_clk);
    endtask : tbl_put

    // ==========================================================
    // scenarios
    task automatic t_flow_err();
        set_cfg(FT_QUAD, 1'b1, 16'h0064, 16'h0100);
        chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
        repeat (4) fpir_flowmeter_model_i.pulse(1'b1, 1'b0, 1'b0);
        chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
        fpir_flowmeter_model_i.pulse(1'b1, 1'b0, 1'b0);
        chk_alarm(alarm, alm(1'b1, 1'b0, ERR_MISSING));
        fpir_flowmeter_model_i.pulse(1'b1, 1'b1, 1'b1);
        chk_alarm(alarm, alm(1'b1, 1'b0, ERR_MISSING));
        press_stop();
        chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
    endtask : t_flow_err

    task automatic t_phase_err();
        set_cfg(FT_QUAD, 1'b1, 16'h0064, 16'h0100);
        repeat (4) fpir_flowmeter_model_i.pulse(1'b1, 1'b1, 1'b0);
        chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
        fpir_flowmeter_model_i.pulse(1'b1, 1'b1, 1'b0);
        chk_alarm(alarm, alm(1'b0, 1'b1, ERR_SIMUL));
    endtask : t_phase_err

    task automatic t_refused();
        for (int i = 0; i < 2; i++) begin
            set_cfg(i == 0 ? FT_SINGLE : FT_QUAD, ~i[0], 16'h0064, 16'h0100);
            repeat (6) fpir_flowmeter_model_i.pulse(1'b1, 1'b0, 1'b0);
            chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
        end
    endtask : t_refused

    // three lost pulses either side of a run end: only a restart keeps it legal
    task automatic t_run_restart();
        set_cfg(FT_QUAD, 1'b1, 16'h0064, 16'h0100);
        repeat (3) fpir_flowmeter_model_i.pulse(1'b1, 1'b0, 1'b0);
        repeat (197) fpir_flowmeter_model_i.pulse(1'b1, 1'b1, 1'b1);
        repeat (3) fpir_flowmeter_model_i.pulse(1'b1, 1'b0, 1'b0);
        chk_alarm(alarm, alm(1'b0, 1'b0, 5'h00));
    endtask : t_run_restart

    task automatic prm_case(input logic [15:0] vmin, input logic [15:0] scale,
                            input logic [1:0] d, input fpir_prompt_t exp);
        set_cfg(FT_QUAD, 1'b1, vmin, scale);
        cfg.total_decimal_setting <= d;
        repeat (3) @(posedge core_clk);
        chk_prompt(prompt, exp);
    endtask : prm_case

    task automatic rate_case(input logic hr, input logic [15:0] s, input logic [15:0] s_exp);
        cfg.rate_per_hour <= hr;
        cfg.scale <= s;
        fpir_flowmeter_model_i.train(80);
        chk32({16'h0000, freq_out}, 32'h14);
        chk32(rate_out, (32'h14 * 32'h100 * (hr ? TB_HOUR : TB_MIN)) / s_exp);
    endtask : rate_case

    task automatic t_rate();
        set_cfg(FT_SINGLE, 1'b0, 16'h0064, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            rate_case(i[0], i[1] ? 16'h0200 : 16'h0100, i[1] ? 16'h0200 : 16'h0100);
        end
        tbl_put(4'h0, 16'h001e, 16'h0300);
        tbl_put(4'h1, 16'h000a, 16'h0100);
        tbl_put(4'h2, 16'h0000, 16'h0100);
        cfg.nl_enable <= 1'b1;
        rate_case(1'b0, 16'h0100, 16'h0200);
        cfg.flow_input_type <= FT_ANALOG;
        rate_case(1'b0, 16'h0100, 16'h0100);
    endtask : t_rate

    // step from 1200 down to 600 with constant two: settles one above, never overshoots
    task automatic t_filter();
        logic [31:0] f;
        f = 32'h0000_04b0;
        for (int i = 0; i < 16; i++) begin
            f = f - (f - 32'h0000_0258) / 32'h0000_0002;
        end
        cfg.filt_a <= 7'h02;
        cfg.scale <= 16'h0200;
        fpir_flowmeter_model_i.train(240);
        chk32(rate_out, f);
    endtask : t_filter

    initial begin
        do_reset();
        chk32(rate_out, 32'h0000_0000);
        t_flow_err();
        t_phase_err();
        t_refused();
        t_run_restart();
        prm_case(16'h0064, 16'h0040, 2'h0, '{1'b1, 16'h0200, 1'b0, 16'h0064});
        prm_case(16'h01f4, 16'h0100, 2'h3, '{1'b0, 16'h0a00, 1'b1, 16'h01f4});
        prm_case(16'h01f3, 16'h0100, 2'h3, '{1'b0, 16'h09fa, 1'b0, 16'h01f3});
        t_rate();
        t_filter();
        complete_run();
    end
endmodule : tb_flow_pulse_integrity_rate
